// File: rtl/spfc_pkg.sv
// Purpose: shared constants for the serial port with flow control
// Assumes: 250 MHz sys_clk
// Notes:   register map of the software port
package spfc_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 250000000;
    localparam int unsigned MS_CYCLES    = CLK_HZ / 1000;
    localparam int unsigned DEF_BAUD_SEL = 5;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_TXDATA = 4'h1;
    localparam logic [3:0] OFS_RXDATA = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;
    localparam logic [3:0] OFS_IRQ_ST = 4'h4;
    localparam logic [3:0] OFS_IRQ_CL = 4'h5;
    localparam logic [3:0] OFS_IRQ_EN = 4'h6;
    localparam logic [3:0] OFS_WAIT   = 4'h7;
    localparam logic [3:0] OFS_XCHR   = 4'h8;
    localparam logic [3:0] OFS_APPLY  = 4'h9;

    // ------------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_BAUD_LSB = 0;
    localparam int unsigned CTRL_PAR_LSB  = 4;
    localparam int unsigned CTRL_STOP_BIT = 7;
    localparam int unsigned CTRL_FLOW_LSB = 8;
    localparam int unsigned CTRL_DIFF_BIT = 10;

    // ------------------------------------------------------------------
    // stored configuration defaults
    // ------------------------------------------------------------------
    localparam logic [15:0] DEF_WAIT_MS = 16'h0000;
    localparam logic [7:0]  DEF_XON     = 8'h11;
    localparam logic [7:0]  DEF_XOFF    = 8'h13;

    // ------------------------------------------------------------------
    // interrupt bits
    // ------------------------------------------------------------------
    localparam int unsigned IRQ_TX_DONE = 0;
    localparam int unsigned IRQ_RX_RDY  = 1;
    localparam int unsigned IRQ_TMO     = 2;
    localparam int unsigned IRQ_PAR_ERR = 3;
    localparam int unsigned IRQ_FRM_ERR = 4;
    localparam int unsigned IRQ_W       = 5;

    typedef enum logic [2:0] {
        SPFC_PAR_NONE,
        SPFC_PAR_EVEN,
        SPFC_PAR_ODD,
        SPFC_PAR_MARK,
        SPFC_PAR_SPACE
    } spfc_par_e;

    typedef enum logic [1:0] {
        SPFC_FLOW_NONE,
        SPFC_FLOW_RTS_SW,
        SPFC_FLOW_RTS_ON,
        SPFC_FLOW_XONXOFF
    } spfc_flow_e;

    // bit period in cycles for each selectable rate
    function automatic logic [19:0] spfc_div(input logic [3:0] sel);
        int unsigned b;
        case (sel)
            4'h0: b = 300;
            4'h1: b = 600;
            4'h2: b = 1200;
            4'h3: b = 2400;
            4'h4: b = 4800;
            4'h6: b = 19200;
            4'h7: b = 28400;
            4'h8: b = 57600;
            4'h9: b = 76800;
            4'hA: b = 115200;
            default: b = 9600;
        endcase
        return 20'((CLK_HZ + b / 2) / b);
    endfunction : spfc_div

endpackage : spfc_pkg

// File: rtl/spfc_uart.sv
// Purpose: character serial port with hardware or software flow control
// Assumes: sys_clk 250 MHz, synchronous active high rst, sync inputs
// Notes:   8 data bits, lsb first; stored config set by apply
`timescale 1ns/1ps
module spfc_uart (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // controller run/stop: a high-to-low edge reloads the stored setup
    input  wire logic        run,
    // register port
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // serial line
    input  wire logic        rxd,
    output logic             txd,
    output logic             rts_n,
    input  wire logic        cts_n,
    // interrupt
    output logic             irq
);

    // ------------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------------
    logic [15:0] st_ctrl_q, rt_ctrl_q;
    logic [15:0] st_wait_q, rt_wait_q;
    logic [15:0] st_xchr_q, rt_xchr_q;
    logic        run_q;
    logic [3:0]  baud_sel;
    spfc_pkg::spfc_par_e  par_mode;
    spfc_pkg::spfc_flow_e flow;
    logic        two_stop;
    logic [19:0] bit_div;
    logic [7:0]  xon_chr, xoff_chr;

    localparam logic [15:0] DEF_CTRL = 16'(spfc_pkg::DEF_BAUD_SEL);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_ctrl_q <= DEF_CTRL;
            st_wait_q <= spfc_pkg::DEF_WAIT_MS;
            st_xchr_q <= {spfc_pkg::DEF_XOFF, spfc_pkg::DEF_XON};
            rt_ctrl_q <= DEF_CTRL;
            rt_wait_q <= spfc_pkg::DEF_WAIT_MS;
            rt_xchr_q <= {spfc_pkg::DEF_XOFF, spfc_pkg::DEF_XON};
            run_q     <= 1'b0;
        end else begin
            run_q <= run;
            if (run_q && !run) begin
                rt_ctrl_q <= st_ctrl_q;
                rt_wait_q <= st_wait_q;
                rt_xchr_q <= st_xchr_q;
            end else if (wr) begin
                // runtime writes override; apply makes them the stored setup
                unique case (addr)
                    spfc_pkg::OFS_CTRL:  rt_ctrl_q <= wdata[15:0];
                    spfc_pkg::OFS_WAIT:  rt_wait_q <= wdata[15:0];
                    spfc_pkg::OFS_XCHR:  rt_xchr_q <= wdata[15:0];
                    spfc_pkg::OFS_APPLY: begin
                        st_ctrl_q <= rt_ctrl_q;
                        st_wait_q <= rt_wait_q;
                        st_xchr_q <= rt_xchr_q;
                    end
                    default: ;
                endcase
            end
        end
    end

    assign baud_sel = rt_ctrl_q[spfc_pkg::CTRL_BAUD_LSB +: 4];
    assign bit_div  = spfc_pkg::spfc_div(baud_sel);
    assign two_stop = rt_ctrl_q[spfc_pkg::CTRL_STOP_BIT];
    assign xon_chr  = rt_xchr_q[7:0];
    assign xoff_chr = rt_xchr_q[15:8];

    always_comb begin
        par_mode = spfc_pkg::spfc_par_e'(rt_ctrl_q[spfc_pkg::CTRL_PAR_LSB +: 3]);
        if (rt_ctrl_q[spfc_pkg::CTRL_PAR_LSB +: 3] > 3'h4)
            par_mode = spfc_pkg::SPFC_PAR_NONE;
        flow = spfc_pkg::spfc_flow_e'(rt_ctrl_q[spfc_pkg::CTRL_FLOW_LSB +: 2]);
        if (rt_ctrl_q[spfc_pkg::CTRL_DIFF_BIT])
            flow = spfc_pkg::SPFC_FLOW_NONE;
    end

    function automatic logic par_bit(input logic [7:0] d, input spfc_pkg::spfc_par_e m);
        logic r;
        r = 1'b0;
        unique case (m)
            spfc_pkg::SPFC_PAR_EVEN:  r = ^d;
            spfc_pkg::SPFC_PAR_ODD:   r = ~^d;
            spfc_pkg::SPFC_PAR_MARK:  r = 1'b1;
            spfc_pkg::SPFC_PAR_SPACE: r = 1'b0;
            spfc_pkg::SPFC_PAR_NONE:  r = 1'b0;
        endcase
        return r;
    endfunction : par_bit

    // ------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} spfc_rx_e;
    spfc_rx_e    rx_st_q;
    logic [19:0] rx_cnt_q;
    logic [2:0]  rx_idx_q;
    logic [7:0]  rx_sh_q, rx_data_q;
    logic        rx_done_q, rx_perr_q, rx_ferr_q, rx_pbad_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_st_q   <= RX_IDLE;
            rx_cnt_q  <= 20'h00000;
            rx_idx_q  <= 3'h0;
            rx_sh_q   <= 8'h00;
            rx_data_q <= 8'h00;
            rx_done_q <= 1'b0;
            rx_perr_q <= 1'b0;
            rx_ferr_q <= 1'b0;
            rx_pbad_q <= 1'b0;
        end else begin
            rx_done_q <= 1'b0;
            rx_perr_q <= 1'b0;
            rx_ferr_q <= 1'b0;
            if (rx_st_q != RX_IDLE && rx_cnt_q != 20'h00000)
                rx_cnt_q <= rx_cnt_q - 20'h00001;
            unique case (rx_st_q)
                RX_IDLE: if (!rxd) begin
                    rx_st_q  <= RX_START;
                    rx_cnt_q <= bit_div >> 1;
                end
                RX_START: if (rx_cnt_q == 20'h00000) begin
                    rx_st_q  <= rxd ? RX_IDLE : RX_DATA;
                    rx_cnt_q <= bit_div;
                    rx_idx_q <= 3'h0;
                end
                RX_DATA: if (rx_cnt_q == 20'h00000) begin
                    rx_sh_q  <= {rxd, rx_sh_q[7:1]};
                    rx_cnt_q <= bit_div;
                    rx_idx_q <= rx_idx_q + 3'h1;
                    if (rx_idx_q == 3'h7)
                        rx_st_q <= (par_mode == spfc_pkg::SPFC_PAR_NONE) ? RX_STOP : RX_PAR;
                end
                RX_PAR: if (rx_cnt_q == 20'h00000) begin
                    rx_pbad_q <= rxd != par_bit(rx_sh_q, par_mode);
                    rx_cnt_q  <= bit_div;
                    rx_st_q   <= RX_STOP;
                end
                RX_STOP: if (rx_cnt_q == 20'h00000) begin
                    rx_st_q   <= RX_IDLE;
                    rx_data_q <= rx_sh_q;
                    rx_done_q <= 1'b1;
                    rx_perr_q <= rx_pbad_q;
                    rx_ferr_q <= !rxd;
                    rx_pbad_q <= 1'b0;
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // xon/xoff tracking
    logic xoff_q;
    logic is_xoff, is_xon;
    assign is_xoff = rx_done_q && flow == spfc_pkg::SPFC_FLOW_XONXOFF && rx_sh_q == xoff_chr;
    assign is_xon  = rx_done_q && flow == spfc_pkg::SPFC_FLOW_XONXOFF && rx_sh_q == xon_chr;

    // ------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_PAR, TX_STOP} spfc_tx_e;
    spfc_tx_e    tx_st_q;
    logic [19:0] tx_cnt_q;
    logic [2:0]  tx_idx_q;
    logic [7:0]  tx_sh_q, tx_hold_q;
    logic        tx_full_q, stop2_q, tx_done_q, tmo_q;
    logic [15:0] ms_q;
    logic [17:0] ms_cyc_q;
    logic        clear, hw_flow;

    assign hw_flow = flow == spfc_pkg::SPFC_FLOW_RTS_SW || flow == spfc_pkg::SPFC_FLOW_RTS_ON;
    always_comb begin
        clear = 1'b1;
        if (hw_flow)
            clear = !cts_n;
        else if (flow == spfc_pkg::SPFC_FLOW_XONXOFF)
            clear = !xoff_q;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            xoff_q <= 1'b0;
        end else if (is_xoff) begin
            xoff_q <= 1'b1;
        end else if (is_xon || flow != spfc_pkg::SPFC_FLOW_XONXOFF || tmo_q) begin
            xoff_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_st_q   <= TX_IDLE;
            tx_cnt_q  <= 20'h00000;
            tx_idx_q  <= 3'h0;
            tx_sh_q   <= 8'h00;
            tx_hold_q <= 8'h00;
            tx_full_q <= 1'b0;
            stop2_q   <= 1'b0;
            tx_done_q <= 1'b0;
            tmo_q     <= 1'b0;
            ms_q      <= 16'h0000;
            ms_cyc_q  <= 18'h00000;
            txd       <= 1'b1;
        end else begin
            tx_done_q <= 1'b0;
            tmo_q     <= 1'b0;
            if (wr && addr == spfc_pkg::OFS_TXDATA && !tx_full_q) begin
                tx_hold_q <= wdata[7:0];
                tx_full_q <= 1'b1;
            end
            if (tx_cnt_q != 20'h00000)
                tx_cnt_q <= tx_cnt_q - 20'h00001;
            unique case (tx_st_q)
                TX_IDLE: begin
                    txd <= 1'b1;
                    if (tx_full_q) begin
                        tx_st_q  <= TX_WAIT;
                        ms_q     <= 16'h0000;
                        ms_cyc_q <= 18'h00000;
                    end
                end
                TX_WAIT: begin
                    if (clear) begin
                        tx_st_q   <= TX_START;
                        tx_sh_q   <= tx_hold_q;
                        tx_full_q <= 1'b0;
                        tx_cnt_q  <= bit_div - 20'h00001;
                        txd       <= 1'b0;
                    end else if (ms_q >= rt_wait_q) begin
                        tx_st_q   <= TX_IDLE;
                        tx_full_q <= 1'b0;
                        tmo_q     <= 1'b1;
                    end else if (ms_cyc_q == 18'(spfc_pkg::MS_CYCLES - 1)) begin
                        ms_cyc_q <= 18'h00000;
                        ms_q     <= ms_q + 16'h0001;
                    end else begin
                        ms_cyc_q <= ms_cyc_q + 18'h00001;
                    end
                end
                TX_START: if (tx_cnt_q == 20'h00000) begin
                    tx_st_q  <= TX_DATA;
                    tx_idx_q <= 3'h0;
                    txd      <= tx_sh_q[0];
                    tx_cnt_q <= bit_div - 20'h00001;
                end
                TX_DATA: if (tx_cnt_q == 20'h00000) begin
                    tx_cnt_q <= bit_div - 20'h00001;
                    tx_idx_q <= tx_idx_q + 3'h1;
                    if (tx_idx_q == 3'h7) begin
                        stop2_q <= two_stop;
                        if (par_mode == spfc_pkg::SPFC_PAR_NONE) begin
                            tx_st_q <= TX_STOP;
                            txd     <= 1'b1;
                        end else begin
                            tx_st_q <= TX_PAR;
                            txd     <= par_bit(tx_sh_q, par_mode);
                        end
                    end else begin
                        txd <= tx_sh_q[tx_idx_q + 3'h1];
                    end
                end
                TX_PAR: if (tx_cnt_q == 20'h00000) begin
                    tx_st_q  <= TX_STOP;
                    txd      <= 1'b1;
                    tx_cnt_q <= bit_div - 20'h00001;
                end
                TX_STOP: if (tx_cnt_q == 20'h00000) begin
                    if (stop2_q) begin
                        stop2_q  <= 1'b0;
                        tx_cnt_q <= bit_div - 20'h00001;
                    end else begin
                        tx_st_q   <= TX_IDLE;
                        tx_done_q <= 1'b1;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // rts
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rts_n <= 1'b1;
        end else if (flow == spfc_pkg::SPFC_FLOW_RTS_ON) begin
            rts_n <= 1'b0;
        end else if (flow == spfc_pkg::SPFC_FLOW_RTS_SW) begin
            rts_n <= !(tx_full_q || tx_st_q != TX_IDLE);
        end else begin
            rts_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // interrupts and read back
    // ------------------------------------------------------------------
    logic [spfc_pkg::IRQ_W-1:0] irq_st_q, irq_en_q, ev;
    assign ev = {rx_ferr_q, rx_perr_q, tmo_q, rx_done_q, tx_done_q};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_st_q <= '0;
            irq_en_q <= '0;
            irq      <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~((wr && addr == spfc_pkg::OFS_IRQ_CL)
                        ? wdata[spfc_pkg::IRQ_W-1:0] : '0)) | ev;
            if (wr && addr == spfc_pkg::OFS_IRQ_EN)
                irq_en_q <= wdata[spfc_pkg::IRQ_W-1:0];
            irq <= |(irq_st_q & irq_en_q);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !rd) begin
            rdata <= 32'h00000000;
        end else begin
            unique case (addr)
                spfc_pkg::OFS_CTRL:   rdata <= {16'h0000, rt_ctrl_q};
                spfc_pkg::OFS_TXDATA: rdata <= {24'h000000, tx_hold_q};
                spfc_pkg::OFS_RXDATA: rdata <= {24'h000000, rx_data_q};
                spfc_pkg::OFS_STATUS: rdata <= {27'h0000000, xoff_q, !cts_n,
                                               tx_st_q == TX_WAIT, tx_st_q != TX_IDLE,
                                               tx_full_q};
                spfc_pkg::OFS_IRQ_ST: rdata <= {27'h0000000, irq_st_q};
                spfc_pkg::OFS_IRQ_EN: rdata <= {27'h0000000, irq_en_q};
                spfc_pkg::OFS_WAIT:   rdata <= {16'h0000, rt_wait_q};
                spfc_pkg::OFS_XCHR:   rdata <= {16'h0000, rt_xchr_q};
                default:              rdata <= 32'h00000000;
            endcase
        end
    end

endmodule : spfc_uart

// File: tb/spfc_chk.sv
// Purpose: port assertions for spfc_uart
// Assumes: one clock domain, synchronous rst
// Notes:   shadows config writes to know the flow mode
`timescale 1ns/1ps
module spfc_chk (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        run,
    // register port
    input wire logic [3:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    // serial line
    input wire logic        rxd,
    input wire logic        txd,
    input wire logic        rts_n,
    input wire logic        cts_n,
    // interrupt
    input wire logic        irq
);
    // ----------------
    // shadow state
    // ----------------
    localparam int unsigned DIV_FAST = 2170;
    logic [10:0] ctrl_q, stored_q;
    logic [4:0]  en_q;
    logic        run_q, last_q, sw_mode, on_mode;
    logic [15:0] cnt_q;

    assign sw_mode = ctrl_q[9:8] == 2'h1 && !ctrl_q[10];
    assign on_mode = ctrl_q[9:8] == 2'h2 && !ctrl_q[10];

    always_ff @(posedge sys_clk) begin
        run_q <= run;
        if (rst) begin
            ctrl_q   <= 11'h005;
            stored_q <= 11'h005;
        end else if (run_q && !run) begin
            ctrl_q <= stored_q;
        end else if (wr && addr == spfc_pkg::OFS_CTRL) begin
            ctrl_q <= wdata[10:0];
        end else if (wr && addr == spfc_pkg::OFS_APPLY) begin
            stored_q <= ctrl_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en_q <= 5'h0;
        end else if (wr && addr == spfc_pkg::OFS_IRQ_EN) begin
            en_q <= wdata[4:0];
        end
    end

    // cycles the line has held its current level
    always_ff @(posedge sys_clk) begin
        last_q <= rst ? 1'b1 : txd;
        if (rst) begin
            cnt_q <= 16'hFFFF;
        end else if (txd != last_q) begin
            cnt_q <= 16'h1;
        end else if (cnt_q != 16'hFFFF) begin
            cnt_q <= cnt_q + 16'h1;
        end
    end

    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_on_held;
        on_mode [*3];
    endsequence
    sequence s_diff_held;
        ctrl_q[10] [*3];
    endsequence
    sequence s_mask_held;
        (en_q == 5'h0) [*2];
    endsequence

    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside a read");
    chk_unmapped_zero: assert property (rd && addr > spfc_pkg::OFS_APPLY
        |=> rdata == 32'h0) else $error("unmapped read returned data");
    chk_ctrl_readback: assert property (rd && addr == spfc_pkg::OFS_CTRL
        |=> rdata[10:0] == $past(ctrl_q)) else $error("control readback differs");
    chk_wait_width: assert property (rd && addr == spfc_pkg::OFS_WAIT
        |=> rdata[31:16] == 16'h0) else $error("wait time wider than 16 bits");
    chk_bit_time: assert property (txd != last_q && ctrl_q[3:0] == 4'hA
        |-> cnt_q >= DIV_FAST) else $error("serial bit shorter than one period");
    chk_irq_masked: assert property (s_mask_held |-> !irq)
        else $error("interrupt raised while all sources masked");
    chk_rts_always_on: assert property (s_on_held |-> !rts_n)
        else $error("rts dropped in always on mode");
    chk_diff_no_flow: assert property (s_diff_held |-> rts_n)
        else $error("rts asserted on differential variant");
    chk_rts_when_send: assert property (sw_mode && !txd |-> !rts_n)
        else $error("sending without rts in switched mode");
endmodule : spfc_chk

bind spfc_uart spfc_chk u_chk (
    .sys_clk(sys_clk), .rst(rst), .run(run), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .rts_n(rts_n),
    .cts_n(cts_n), .irq(irq)
);

// File: tb/spfc_peer.sv
// Purpose: remote serial device facing spfc_uart
// Assumes: 8 data bits, parity always present, one stop bit sent
// Notes:   frames seen on txd are queued with parity and stops
`timescale 1ns/1ps
module spfc_peer #(
    parameter int BIT = 2170
) (
    // clock
    input  wire logic sys_clk,
    // line from the port
    input  wire logic txd,
    input  wire logic rts_n,
    // line into the port
    output logic      rxd,
    output logic      cts_n
);
    // ----------------
    // remote behaviour
    // ----------------
    logic        cts_on = 1'b0, honor_rts = 1'b0;
    logic [10:0] frames[$];

    initial rxd = 1'b1;
    assign cts_n = !cts_on;

    task automatic send(input logic [7:0] d, input logic p);
        logic [9:0] f;
        f = {1'b1, p, d};
        wait (!honor_rts || !rts_n);
        @(posedge sys_clk);
        rxd <= 1'b0;
        repeat (BIT) @(posedge sys_clk);
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge sys_clk);
        end
    endtask : send

    // samples mid bit: data, parity, two stops
    always begin : mon
        logic [10:0] f;
        @(negedge txd);
        repeat (BIT / 2) @(posedge sys_clk);
        for (int i = 0; i < 11; i++) begin
            repeat (BIT) @(posedge sys_clk);
            f[i] = txd;
        end
        frames.push_back(f);
    end
endmodule : spfc_peer

// File: tb/spfc_uart_bench.sv
// Purpose: self-checking bench for spfc_uart
// Assumes: peer model on the serial side, traffic at 115200 baud
// Notes:   wait of 1 ms spans the cts pause, 0 ms forces aborts
`timescale 1ns/1ps
module spfc_uart_bench;
    // ----------------
    // signals and model
    // ----------------
    localparam int BIT = 2170;
    logic        sys_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic        run       = 1'b1;
    logic [3:0]  addr      = 4'h0;
    logic [31:0] wdata     = 32'h0;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic [31:0] rdata;
    logic        rxd, txd, rts_n, cts_n, irq;
    int          bad_count = 0;
    int          checks    = 0;
    int          m_ctrl;
    int          m_stored;
    logic [10:0] exp_q[$];

    always #2 sys_clk = ~sys_clk;

    spfc_uart u_dut (
        .sys_clk(sys_clk), .rst(rst), .run(run), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .rts_n(rts_n),
        .cts_n(cts_n), .irq(irq)
    );
    spfc_peer #(.BIT(BIT)) u_peer (
        .sys_clk(sys_clk), .txd(txd), .rts_n(rts_n), .rxd(rxd), .cts_n(cts_n)
    );

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t reg got %h exp %h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_line(input logic [10:0] got, input logic [10:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t line got %h exp %h", $time, got, exp);
        end
    endtask : cmp_line

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 cmp_reg(rdata, exp);
    endtask : rd_chk

    task automatic pulse_stop;
        @(posedge sys_clk);
        run <= 1'b0;
        repeat (2) @(posedge sys_clk);
        run <= 1'b1;
        m_ctrl = m_stored;
    endtask : pulse_stop

    task automatic send_tx(input logic [7:0] d);
        exp_q.push_back({2'b11, ~^d, d});
        repeat (2) @(posedge sys_clk);
        wr_reg(spfc_pkg::OFS_TXDATA, {24'h0, d});
    endtask : send_tx

    task automatic chk_frame;
        int n = 0;
        while (u_peer.frames.size() == 0 && n < 40000) begin
            @(posedge sys_clk);
            n++;
        end
        cmp_line((n < 40000) ? u_peer.frames.pop_front() : 11'h0, exp_q.pop_front());
    endtask : chk_frame

    // ----------------
    // scenarios
    // ----------------
    initial begin
        logic [31:0] v;
        logic [7:0]  d0, d1, xon, xoff;
        void'($urandom(32'h9508));
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        m_ctrl   = 32'h5;
        m_stored = 32'h5;
        cmp_line(11'(txd), 11'h1);
        cmp_line(11'(rts_n), 11'h1);
        cmp_line(11'(irq), 11'h0);
        rd_chk(spfc_pkg::OFS_CTRL, m_ctrl);
        rd_chk(spfc_pkg::OFS_WAIT, 32'h0);
        rd_chk(spfc_pkg::OFS_XCHR, {16'h0, spfc_pkg::DEF_XOFF, spfc_pkg::DEF_XON});
        rd_chk(4'hF, 32'h0);
        // runtime setup, stop restores stored
        v = {21'h0, 1'b1, 2'($urandom_range(3)), 1'($urandom),
             3'($urandom_range(4)), 4'($urandom_range(10))};
        m_ctrl = v;
        wr_reg(spfc_pkg::OFS_CTRL, v);
        rd_chk(spfc_pkg::OFS_CTRL, m_ctrl);
        pulse_stop;
        rd_chk(spfc_pkg::OFS_CTRL, m_ctrl);
        wr_reg(spfc_pkg::OFS_CTRL, v);
        wr_reg(spfc_pkg::OFS_APPLY, 32'h0);
        m_stored = v;
        pulse_stop;
        rd_chk(spfc_pkg::OFS_CTRL, m_ctrl);
        // rts always on, then differential
        wr_reg(spfc_pkg::OFS_CTRL, 32'h205);
        repeat (3) @(posedge sys_clk);
        cmp_line(11'(rts_n), 11'h0);
        wr_reg(spfc_pkg::OFS_CTRL, 32'h605);
        repeat (3) @(posedge sys_clk);
        cmp_line(11'(rts_n), 11'h1);
        // switched, cts pause
        wr_reg(spfc_pkg::OFS_IRQ_EN, 32'h1F);
        wr_reg(spfc_pkg::OFS_WAIT, 32'h1);
        wr_reg(spfc_pkg::OFS_CTRL, 32'h1AA);
        u_peer.cts_on <= 1'b1;
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        send_tx(d0);
        send_tx(d1);
        repeat (BIT) @(posedge sys_clk);
        u_peer.cts_on <= 1'b0;
        chk_frame;
        repeat (2 * BIT) @(posedge sys_clk);
        cmp_line(11'(u_peer.frames.size()), 11'h0);
        cmp_line(11'(txd), 11'h1);
        u_peer.cts_on <= 1'b1;
        chk_frame;
        repeat (BIT) @(posedge sys_clk);
        rd_chk(spfc_pkg::OFS_IRQ_ST, 32'h1);
        cmp_line(11'(irq), 11'h1);
        wr_reg(spfc_pkg::OFS_IRQ_EN, 32'h0);
        repeat (2) @(posedge sys_clk);
        cmp_line(11'(irq), 11'h0);
        wr_reg(spfc_pkg::OFS_IRQ_EN, 32'h1F);
        wr_reg(spfc_pkg::OFS_IRQ_CL, 32'h1);
        rd_chk(spfc_pkg::OFS_IRQ_ST, 32'h0);
        // zero wait with cts absent aborts
        wr_reg(spfc_pkg::OFS_WAIT, 32'h0);
        u_peer.cts_on <= 1'b0;
        wr_reg(spfc_pkg::OFS_TXDATA, {24'h0, d0});
        repeat (20) @(posedge sys_clk);
        rd_chk(spfc_pkg::OFS_IRQ_ST, 32'h4);
        cmp_line(11'(irq), 11'h1);
        wr_reg(spfc_pkg::OFS_IRQ_CL, 32'h4);
        // software flow with own codes
        xon  = 8'($urandom);
        xoff = xon ^ 8'h5A;
        wr_reg(spfc_pkg::OFS_XCHR, {16'h0, xoff, xon});
        wr_reg(spfc_pkg::OFS_CTRL, 32'h32A);
        u_peer.send(xoff, ~^xoff);
        repeat (BIT) @(posedge sys_clk);
        rd_chk(spfc_pkg::OFS_RXDATA, {24'h0, xoff});
        rd_chk(spfc_pkg::OFS_STATUS, 32'h10);
        wr_reg(spfc_pkg::OFS_TXDATA, {24'h0, d1});
        repeat (20) @(posedge sys_clk);
        rd_chk(spfc_pkg::OFS_IRQ_ST, 32'h6);
        cmp_line(11'(u_peer.frames.size()), 11'h0);
        final_report;
    end

    initial begin
        repeat (120000) @(posedge sys_clk);
        bad_count++;
        final_report;
    end
endmodule : spfc_uart_bench
